// file: rcc_converter.sv
// Control and register logic of a resistance-to-digital converter.
// Assumes serial port pins and analog comparator levels arrive asynchronous to ref_clk.
//
// Functional notes
// [R1] Eight byte-wide registers: config, result, thresholds, fault status.
// [R2] Address byte bit 7 set means write, clear means read.
// [R3] Every byte moves most significant bit first.
// [R4] Result is a 15-bit ratio of sensor to reference voltage.
// [R5] Negative differential input gives result code zero.
// [R6] Input above reference saturates result at full scale.
// [R7] Result at or above upper, or at or below lower limit flags fault.
// [R8] Over/undervoltage sets status bit 2 and freezes results while present.
// [R9] Fault detection cycle runs only on request via config bits 3:2.
// [R10] Fault cycle can open the return ground switch.
// [R11] Config bit 7 enables bias; continuous mode keeps bias on.
// [R12] Config bit 6 selects continuous conversion, else normally off.
// [R13] One-shot bit starts one conversion at the following chip select rise.
// [R14] In multibyte writes one-shot waits for the final chip select rise.
// [R15] One-shot bit self-clears once its conversion has started.
// [R16] Conversion lasts 52 ms with 60 Hz notch, 62.5 ms with 50 Hz.
// [R17] Master waits settling time after enabling bias before one-shot.
// [R18] Three-wire bit selects lead voltage compensation in front end.
// [R19] Third-order sinc decimation filters the modulator stream.
// [R20] Upper limits reset to FFh, everything else to 00h.
// [R21] Ready output falls on new result, rises on result register read.
// [R22] Config bit 1 with bits 5,3,2 zero clears fault bits 7:2.
// [R23] Result low byte bit 0 shows any detected fault.
// [R24] Address byte first, then data bytes at consecutive addresses.
// [R25] Writes to read-only registers are ignored.
`timescale 1ns/1ps
`include "rcc_regs.svh"

module rcc_converter #(
   parameter int CONV60_CYC   = `RCC_CONV60_US * `RCC_CLK_MHZ,
   parameter int CONV50_CYC   = `RCC_CONV50_US * `RCC_CLK_MHZ,
   parameter int FD_DELAY_CYC = `RCC_FD_DELAY_US * `RCC_CLK_MHZ,
   parameter int DEC          = 32,
   parameter int SINC_W       = 16
) (
   // Clock, reset, enable
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   // Serial port
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic sdi,
   output logic      sdo,
   output logic      sdo_oe,
   output logic      result_ready_n,
   // Analog front end
   input  wire logic modulator_bit,
   input  wire logic input_negative,
   input  wire logic overvoltage_detect,
   input  wire logic reference_input_pos_above,
   input  wire logic reference_input_pos_below,
   input  wire logic sensor_input_pos_below,
   output logic      bias_voltage_en,
   output logic      three_wire_sense,
   output logic      notch_50hz,
   output logic      return_switch_open
);
   import rcc_pkg::*;

   localparam int NS = 9;
   localparam int DW = $clog2(DEC);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; stage one is read only by stage two
   logic [NS-1:0] s1;
   logic [NS-1:0] s2;
   logic          sclk_q;
   logic          cs_q;
   // Reset to pin idle levels: all ones would fake an overvoltage fault
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1     <= 9'h002;
         s2     <= 9'h002;
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
      end else if (clk_en) begin
         s1     <= {sensor_input_pos_below, reference_input_pos_below, reference_input_pos_above, overvoltage_detect,
                    input_negative, modulator_bit, sdi, cs_n, sclk};
         s2     <= s1;
         sclk_q <= s2[0];
         cs_q   <= s2[1];
      end
   end
   wire sclk_l  = s2[0];
   wire cs_l    = s2[1];
   wire sdi_l   = s2[2];
   wire mod_l   = s2[3];
   wire neg_l   = s2[4];
   wire ovuv_l  = s2[5];
   wire rhi_l   = s2[6];
   wire rlo_l   = s2[7];
   wire tlo_l   = s2[8];
   wire sclk_rise = sclk_l & ~sclk_q;
   wire sclk_fall = ~sclk_l & sclk_q;
   wire cs_fall   = ~cs_l & cs_q;
   wire cs_rise   = cs_l & ~cs_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register state (declared early for the read mux)
   rcc_byte_t cfg;
   rcc_byte_t up_hi, up_lo, lo_hi, lo_lo, flt;
   logic [14:0] result;
   logic        pend;
   logic [1:0]  fd_code;

   function automatic rcc_byte_t reg_read(input logic [2:0] a);
      unique case (a)
         `RCC_ADDR_CFG:    reg_read = {cfg[7:6], pend, cfg[4], fd_code, 1'b0, cfg[0]};
         `RCC_ADDR_RES_HI: reg_read = result[14:7];
         `RCC_ADDR_RES_LO: reg_read = {result[6:0], |flt[7:2]}; // R23
         `RCC_ADDR_UHI:    reg_read = up_hi;
         `RCC_ADDR_ULO:    reg_read = up_lo;
         `RCC_ADDR_LHI:    reg_read = lo_hi;
         `RCC_ADDR_LLO:    reg_read = lo_lo;
         `RCC_ADDR_FLT:    reg_read = flt;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave: sample on SCLK rise, shift out on SCLK fall
   logic [2:0] bit_cnt, next_bit_cnt;
   rcc_byte_t  rx, next_rx, tx, next_tx;
   logic       first, next_first, wr, next_wr;
   logic [2:0] addr, next_addr;
   logic       next_sdo, next_sdo_oe;
   logic       wr_stb, rd_res_stb;
   rcc_byte_t  wr_data;

   always_comb begin
      logic [2:0] rd_a;
      logic       rd_go;
      rd_a         = addr;
      rd_go        = 1'b0;
      next_bit_cnt = bit_cnt;
      next_rx      = rx;
      next_tx      = tx;
      next_first   = first;
      next_wr      = wr;
      next_addr    = addr;
      next_sdo     = sdo;
      next_sdo_oe  = ~cs_l;
      wr_stb       = 1'b0;
      rd_res_stb   = 1'b0;
      wr_data      = {rx[6:0], sdi_l};
      if (cs_fall) begin
         next_bit_cnt = 3'h0;
         next_first   = 1'b1; // R24
      end else if (!cs_l && sclk_rise) begin
         next_rx      = {rx[6:0], sdi_l}; // R3
         next_bit_cnt = bit_cnt + 3'h1;
         if (bit_cnt == 3'h7) begin
            if (first) begin
               next_first = 1'b0;
               next_wr    = wr_data[`RCC_WRITE_BIT]; // R2
               next_addr  = wr_data[2:0];
               rd_a       = wr_data[2:0];
               rd_go      = ~wr_data[`RCC_WRITE_BIT];
            end else begin
               wr_stb    = wr;
               rd_a      = addr + 3'h1;
               next_addr = rd_a; // R24
               rd_go     = ~wr;
            end
            if (rd_go) begin
               next_tx    = reg_read(rd_a);
               rd_res_stb = (rd_a == `RCC_ADDR_RES_HI) || (rd_a == `RCC_ADDR_RES_LO);
            end
         end
      end else if (!cs_l && sclk_fall) begin
         next_sdo = tx[7]; // R3
         next_tx  = {tx[6:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bit_cnt <= 3'h0;
         rx      <= 8'h00;
         tx      <= 8'h00;
         first   <= 1'b1;
         wr      <= 1'b0;
         addr    <= 3'h0;
         sdo     <= 1'b0;
         sdo_oe  <= 1'b0;
      end else if (clk_en) begin
         bit_cnt <= next_bit_cnt;
         rx      <= next_rx;
         tx      <= next_tx;
         first   <= next_first;
         wr      <= next_wr;
         addr    <= next_addr;
         sdo     <= next_sdo;
         sdo_oe  <= next_sdo_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sinc3 decimator; DEC cubed equals full scale plus one
   logic [SINC_W-1:0] i1, i2, i3, z3, c1z, c2z, y;
   logic [DW-1:0]     dec_cnt;
   wire               dec_wrap = (dec_cnt == DW'(DEC - 1));
   wire  [SINC_W-1:0] d1 = i3 - z3;
   wire  [SINC_W-1:0] d2 = d1 - c1z;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         {i1, i2, i3, z3, c1z, c2z, y} <= '0;
         dec_cnt <= '0;
      end else if (clk_en) begin
         i1      <= i1 + SINC_W'(mod_l); // R19
         i2      <= i2 + i1;
         i3      <= i3 + i2;
         dec_cnt <= dec_cnt + DW'(1);
         if (dec_wrap) begin
            z3  <= i3;
            c1z <= d1;
            c2z <= d2;
            y   <= d2 - c2z;
         end
      end
   end

   // Negative input clamps to zero, overrange saturates
   wire [14:0] code = neg_l ? 15'h0000 :                  // R5
                      y[15] ? `RCC_FULL_SCALE : y[14:0]; // R4 R6

   ////////////////////////////////////////////////////////////////////////////
   // Configuration, conversion sequencing and fault handling
   rcc_byte_t   next_cfg, next_up_hi, next_up_lo, next_lo_hi, next_lo_lo, next_flt;
   logic [14:0] next_result;
   logic        next_pend, armed, next_armed, next_rdy_n;
   logic [1:0]  next_fd_code;
   rcc_conv_e   cv, next_cv;
   rcc_fd_e     fd, next_fd;
   logic [23:0] cv_cnt, next_cv_cnt;
   logic [15:0] fd_cnt, next_fd_cnt;
   logic        sw_open, next_sw_open;

   wire [14:0] up15 = {up_hi, up_lo[7:1]};
   wire [14:0] lo15 = {lo_hi, lo_lo[7:1]};

   always_comb begin
      rcc_byte_t fset;
      logic      both;
      fset         = 8'h00;
      both         = 1'b0;
      next_cfg     = cfg;
      next_up_hi   = up_hi;
      next_up_lo   = up_lo;
      next_lo_hi   = lo_hi;
      next_lo_lo   = lo_lo;
      next_flt     = flt;
      next_result  = result;
      next_pend    = pend;
      next_armed   = armed;
      next_rdy_n   = result_ready_n | rd_res_stb; // R21
      next_fd_code = fd_code;
      next_cv      = cv;
      next_fd      = fd;
      next_cv_cnt  = cv_cnt;
      next_fd_cnt  = fd_cnt;
      next_sw_open = sw_open;
      if (wr_stb) begin
         unique case (addr)
            `RCC_ADDR_CFG: begin
               both = wr_data[`RCC_CFG_ONESHOT] & (wr_data[3] | wr_data[2]);
               next_cfg = {wr_data[7:6], 1'b0, wr_data[4], 3'b000, wr_data[0]}; // R11 R12 R18
               if (!both && wr_data[`RCC_CFG_ONESHOT] && !wr_data[`RCC_CFG_AUTO])
                  next_pend = 1'b1; // R13
               if (!both && wr_data[3:2] != 2'b00) begin // R9
                  if (fd == FD_HOLD && wr_data[3:2] == 2'b11) begin
                     next_fd      = FD_CHECK_OPEN;
                     next_fd_code = 2'b11;
                  end else if (fd == FD_IDLE && wr_data[3:2] == 2'b10) begin
                     fset[`RCC_FLT_REF_HI] = rhi_l;
                     next_sw_open = 1'b1; // R10
                     next_fd      = FD_HOLD;
                     next_fd_code = 2'b10;
                  end else if (fd == FD_IDLE) begin
                     next_fd      = FD_SETTLE_CLOSED;
                     next_fd_code = 2'b01;
                     next_fd_cnt  = 16'(FD_DELAY_CYC);
                  end
               end
               if (wr_data[1] && wr_data[5:2] ==? 4'b0?00)
                  next_flt = 8'h00; // R22
            end
            `RCC_ADDR_UHI: next_up_hi = wr_data;
            `RCC_ADDR_ULO: next_up_lo = wr_data;
            `RCC_ADDR_LHI: next_lo_hi = wr_data;
            `RCC_ADDR_LLO: next_lo_lo = wr_data;
            default: ; // R25
         endcase
      end
      // Trigger waits for chip select rise, which ends a multibyte write
      if (pend && cs_rise)
         next_armed = 1'b1; // R14
      unique case (fd)
         FD_IDLE, FD_HOLD: ;
         FD_SETTLE_CLOSED: begin
            next_fd_cnt = fd_cnt - 16'h0001;
            if (fd_cnt == 16'h0000) begin
               fset[`RCC_FLT_REF_HI] = rhi_l;
               next_sw_open = 1'b1; // R10
               next_fd_cnt  = 16'(FD_DELAY_CYC);
               next_fd      = FD_SETTLE_OPEN;
            end
         end
         FD_SETTLE_OPEN, FD_CHECK_OPEN: begin
            next_fd_cnt = fd_cnt - 16'h0001;
            if (fd == FD_CHECK_OPEN || fd_cnt == 16'h0000) begin
               fset[`RCC_FLT_REF_LO] = rlo_l;
               fset[`RCC_FLT_RTD_LO] = tlo_l;
               next_sw_open = 1'b0;
               next_fd_code = 2'b00;
               next_fd      = FD_IDLE;
            end
         end
      endcase
      unique case (cv)
         CV_IDLE: begin
            if (cfg[`RCC_CFG_AUTO] || (armed && pend)) begin
               next_cv     = CV_RUN;
               next_pend   = 1'b0; // R15
               next_armed  = 1'b0;
               next_cv_cnt = cfg[`RCC_CFG_NOTCH50] ? 24'(CONV50_CYC) : 24'(CONV60_CYC); // R16
            end
         end
         CV_RUN: begin
            next_cv_cnt = cv_cnt - 24'h000001;
            if (cv_cnt == 24'h000000) begin
               next_cv = CV_IDLE;
               if (!ovuv_l) begin // R8
                  next_result = code;
                  next_rdy_n  = 1'b0; // R21
                  fset[`RCC_FLT_HIGH] = (code >= up15); // R7
                  fset[`RCC_FLT_LOW]  = (code <= lo15); // R7
               end
            end
         end
      endcase
      fset[`RCC_FLT_OVUV] = ovuv_l; // R8
      next_flt = next_flt | fset;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg                <= `RCC_RST_CFG; // R20
         up_hi              <= `RCC_RST_UPPER;
         up_lo              <= `RCC_RST_UPPER;
         lo_hi              <= `RCC_RST_LOWER;
         lo_lo              <= `RCC_RST_LOWER;
         flt                <= `RCC_RST_ZERO;
         result             <= 15'h0000;
         pend               <= 1'b0;
         armed              <= 1'b0;
         fd_code            <= 2'b00;
         cv                 <= CV_IDLE;
         fd                 <= FD_IDLE;
         cv_cnt             <= 24'h000000;
         fd_cnt             <= 16'h0000;
         sw_open            <= 1'b0;
         result_ready_n     <= 1'b1;
         bias_voltage_en    <= 1'b0;
         three_wire_sense   <= 1'b0;
         notch_50hz         <= 1'b0;
         return_switch_open <= 1'b0;
      end else if (clk_en) begin
         cfg                <= next_cfg; // R1
         up_hi              <= next_up_hi;
         up_lo              <= next_up_lo;
         lo_hi              <= next_lo_hi;
         lo_lo              <= next_lo_lo;
         flt                <= next_flt;
         result             <= next_result;
         pend               <= next_pend;
         armed              <= next_armed;
         fd_code            <= next_fd_code;
         cv                 <= next_cv;
         fd                 <= next_fd;
         cv_cnt             <= next_cv_cnt;
         fd_cnt             <= next_fd_cnt;
         sw_open            <= next_sw_open;
         result_ready_n     <= next_rdy_n;
         bias_voltage_en    <= next_cfg[`RCC_CFG_BIAS] | next_cfg[`RCC_CFG_AUTO]; // R11
         three_wire_sense   <= next_cfg[`RCC_CFG_3WIRE]; // R18
         notch_50hz         <= next_cfg[`RCC_CFG_NOTCH50];
         return_switch_open <= next_sw_open; // R10
      end
   end
endmodule

// file: rcc_converter_assertions.sv
// Port-level checker for the converter control block.
// Assumes ref_clk domain only; bound to every rcc_converter instance.
`timescale 1ns/1ps
module rcc_converter_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial port
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic result_ready_n,
   // Front end
   input wire logic overvoltage_detect,
   input wire logic bias_voltage_en,
   input wire logic three_wire_sense,
   input wire logic notch_50hz,
   input wire logic return_switch_open
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   a_oe_idle: assert property (cs_n [*6] |-> !sdo_oe)
      else $error("sdo_oe high with chip select idle");
   a_oe_active: assert property ((!cs_n) [*6] |-> sdo_oe)
      else $error("sdo_oe low inside a frame");
   // Data only moves after falling sclk, so a long high phase is quiet
   a_sdo_hold: assert property (sclk [*6] |-> $stable(sdo))
      else $error("sdo changed while sclk high");
   a_ready_rise: assert property ($rose(result_ready_n) |-> !cs_n)
      else $error("ready released outside a read");
   a_ov_nostore: assert property (overvoltage_detect [*8] |-> !$fell(result_ready_n))
      else $error("result stored during overvoltage");
   a_cfg_quiet: assert property (cs_n [*8] |->
      $stable({bias_voltage_en, three_wire_sense, notch_50hz}))
      else $error("config outputs moved without a write");
   a_switch_bias: assert property (return_switch_open |-> bias_voltage_en)
      else $error("return switch open with bias off");
   a_rst_vals: assert property (disable iff (1'b0) !rst_n |=> (!sdo_oe && result_ready_n
      && !bias_voltage_en && !return_switch_open && !notch_50hz))
      else $error("outputs not at reset values");
endmodule
bind rcc_converter rcc_converter_chk u_chk (
   .ref_clk            (ref_clk),
   .rst_n              (rst_n),
   .sclk               (sclk),
   .cs_n               (cs_n),
   .sdo                (sdo),
   .sdo_oe             (sdo_oe),
   .result_ready_n     (result_ready_n),
   .overvoltage_detect (overvoltage_detect),
   .bias_voltage_en    (bias_voltage_en),
   .three_wire_sense   (three_wire_sense),
   .notch_50hz         (notch_50hz),
   .return_switch_open (return_switch_open)
);

// file: rcc_converter_tb.sv
// Self-checking bench for the converter control block.
// Assumes the SPI master model on the serial port; analog levels come from here.
`timescale 1ns/1ps
module rcc_converter_tb;
   import rcc_pkg::*;
   logic      ref_clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, result_ready_n, rx_done;
   logic      modulator_bit, input_negative, overvoltage_detect;
   logic      reference_input_pos_above, reference_input_pos_below, sensor_input_pos_below;
   logic      bias_voltage_en, three_wire_sense, notch_50hz, return_switch_open;
   rcc_byte_t rx_byte;
   rcc_byte_t exp_q [$];
   rcc_byte_t rnd [$];
   int        failures = 0;
   int        num_checks = 0;
   int        cycles = 0;
   int        n;
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Short counts keep conversions to a few thousand cycles
   rcc_converter #(.CONV60_CYC(2000), .CONV50_CYC(2500), .FD_DELAY_CYC(50)) u_dut (
      .ref_clk            (ref_clk),
      .rst_n              (rst_n),
      .clk_en             (1'b1),
      .sclk               (sclk),
      .cs_n               (cs_n),
      .sdi                (sdi),
      .sdo                (sdo),
      .sdo_oe             (sdo_oe),
      .result_ready_n     (result_ready_n),
      .modulator_bit      (modulator_bit),
      .input_negative     (input_negative),
      .overvoltage_detect (overvoltage_detect),
      .reference_input_pos_above        (reference_input_pos_above),
      .reference_input_pos_below        (reference_input_pos_below),
      .sensor_input_pos_below        (sensor_input_pos_below),
      .bias_voltage_en    (bias_voltage_en),
      .three_wire_sense   (three_wire_sense),
      .notch_50hz         (notch_50hz),
      .return_switch_open (return_switch_open)
   );
   rcc_spi_master u_spi (
      .sclk    (sclk),
      .cs_n    (cs_n),
      .sdi     (sdi),
      .sdo     (sdo),
      .rx_done (rx_done),
      .rx_byte (rx_byte)
   );
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (failures == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input rcc_byte_t a, input rcc_byte_t d [$]);
      tick(1);
      u_spi.xfer(a | 8'h80, d);
   endtask
   task automatic rd(input rcc_byte_t a, input rcc_byte_t e [$]);
      foreach (e[k]) exp_q.push_back(e[k]);
      tick(1);
      u_spi.xfer(a, e);
   endtask
   // Delay is counted from the return of the last transfer
   task automatic wait_ready(input int lo, input int hi);
      for (n = 0; n < hi + 20 && result_ready_n !== 1'b0; n++) tick(1);
      check("ready_delay", 16'(n >= lo && n <= hi), 16'h0001);
   endtask
   always @(posedge rx_done) begin
      if (exp_q.size() == 0) check("rx_extra", 16'h0001, 16'h0000);
      else check("rx_byte", 16'(rx_byte), 16'(exp_q.pop_front()));
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      modulator_bit = 1'b0;
      input_negative = 1'b0;
      overvoltage_detect = 1'b0;
      reference_input_pos_above = 1'b0;
      reference_input_pos_below = 1'b0;
      sensor_input_pos_below = 1'b0;
      void'($urandom(21517));
      tick(20);
      rst_n = 1'b1;
      tick(4);
      rd(8'h00, {8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00});
      rnd = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
      wr(8'h03, rnd);
      rd(8'h03, rnd);
      wr(8'h01, {8'hFF, 8'hFF});
      wr(8'h07, {8'hFF});
      rd(8'h01, {8'h00, 8'h00});
      rd(8'h07, {8'h00});
      wr(8'h04, {8'h00, 8'h00, 8'h00});
      modulator_bit = 1'b1;
      wr(8'h00, {8'h80});
      tick(200);
      wr(8'h00, {8'hA0, 8'h00, 8'h00, 8'h40});
      wait_ready(1960, 2000);
      check("bias", 16'(bias_voltage_en), 16'h0001);
      rd(8'h00, {8'h80});
      rd(8'h01, {8'hFF, 8'hFF});
      check("ready_n", 16'(result_ready_n), 16'h0001);
      rd(8'h07, {8'h80});
      input_negative = 1'b1;
      wr(8'h00, {8'hA1});
      wait_ready(2460, 2500);
      check("notch", 16'(notch_50hz), 16'h0001);
      rd(8'h01, {8'h00, 8'h01});
      rd(8'h07, {8'hC0});
      wr(8'h00, {8'h82});
      rd(8'h07, {8'h00});
      overvoltage_detect = 1'b1;
      wr(8'h00, {8'hC0});
      tick(3000);
      check("ready_n", 16'(result_ready_n), 16'h0001);
      rd(8'h07, {8'h04});
      check("bias", 16'(bias_voltage_en), 16'h0001);
      overvoltage_detect = 1'b0;
      wait_ready(0, 2100);
      rd(8'h02, {8'h01, 8'h40});
      wait_ready(0, 2010);
      rd(8'h07, {8'h44});
      // A conversion still in flight may set flags again, so clear twice
      wr(8'h00, {8'h82});
      tick(2600);
      wr(8'h00, {8'h82});
      wr(8'h00, {8'hA4});
      rd(8'h00, {8'h80});
      reference_input_pos_above = 1'b1;
      wr(8'h00, {8'h84});
      for (n = 0; n < 200 && return_switch_open !== 1'b1; n++) tick(1);
      check("switch", 16'(return_switch_open), 16'h0001);
      for (n = 0; n < 200 && return_switch_open !== 1'b0; n++) tick(1);
      rd(8'h00, {8'h80});
      reference_input_pos_below = 1'b1;
      sensor_input_pos_below = 1'b1;
      wr(8'h00, {8'h88});
      tick(10);
      check("switch", 16'(return_switch_open), 16'h0001);
      rd(8'h00, {8'h88});
      wr(8'h00, {8'h8C});
      rd(8'h00, {8'h80});
      rd(8'h07, {8'h38});
      wr(8'h00, {8'h11});
      check("three_wire", 16'(three_wire_sense), 16'h0001);
      check("bias", 16'(bias_voltage_en), 16'h0000);
      rst_n = 1'b0;
      tick(4);
      rst_n = 1'b1;
      tick(4);
      rd(8'h03, {8'hFF, 8'hFF});
      finish_test();
   end
endmodule

// file: rcc_pkg.sv
// Types shared by the converter control block.
// Constants live in rcc_regs.svh.
package rcc_pkg;
   typedef logic [7:0] rcc_byte_t;
   typedef enum logic [2:0] {
      FD_IDLE, FD_SETTLE_CLOSED, FD_SETTLE_OPEN, FD_HOLD, FD_CHECK_OPEN
   } rcc_fd_e;
   typedef enum logic {CV_IDLE, CV_RUN} rcc_conv_e;
endpackage

// file: rcc_regs.svh
// Register map, field positions, reset values and timing of the converter control block.
// Assumes a single 100 MHz reference clock; included by the package user only.
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH

// Register addresses (read form; the write form adds the top bit)
`define RCC_ADDR_CFG      3'h0
`define RCC_ADDR_RES_HI   3'h1
`define RCC_ADDR_RES_LO   3'h2
`define RCC_ADDR_UHI      3'h3
`define RCC_ADDR_ULO      3'h4
`define RCC_ADDR_LHI      3'h5
`define RCC_ADDR_LLO      3'h6
`define RCC_ADDR_FLT      3'h7
`define RCC_WRITE_BIT     7

// Configuration fields
`define RCC_CFG_BIAS      7
`define RCC_CFG_AUTO      6
`define RCC_CFG_ONESHOT   5
`define RCC_CFG_3WIRE     4
`define RCC_CFG_FD_HI     3
`define RCC_CFG_FD_LO     2
`define RCC_CFG_FCLR      1
`define RCC_CFG_NOTCH50   0

// Fault status fields
`define RCC_FLT_HIGH      7
`define RCC_FLT_LOW       6
`define RCC_FLT_REF_HI    5
`define RCC_FLT_REF_LO    4
`define RCC_FLT_RTD_LO    3
`define RCC_FLT_OVUV      2

// Reset values and full-scale result code
`define RCC_RST_CFG       8'h00
`define RCC_RST_UPPER     8'hFF
`define RCC_RST_LOWER     8'h00
`define RCC_RST_ZERO      8'h00
`define RCC_FULL_SCALE    15'h7FFF

// Timing
`define RCC_CLK_MHZ       100
`define RCC_CONV60_US     52000
`define RCC_CONV50_US     62500
`define RCC_FD_DELAY_US   100

`endif

// file: rcc_spi_master.sv
// Behavioural SPI master driving the converter's serial port.
// Assumes the bench calls xfer; sclk idles low and stands still between frames.
`timescale 1ns/1ps
module rcc_spi_master (
   // Serial port
   output logic              sclk,
   output logic              cs_n,
   output logic              sdi,
   input  wire logic         sdo,
   // Read data handed to the bench
   output logic              rx_done,
   output rcc_pkg::rcc_byte_t rx_byte
);
   import rcc_pkg::*;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b1;
      rx_done = 1'b0;
      rx_byte = 8'h00;
   end
   // Sample at the rise, well after the device moved sdo on the fall
   task automatic shift(input rcc_byte_t tx, output rcc_byte_t rx);
      for (int i = 7; i >= 0; i--) begin
         sdi = tx[i];
         #62.5 sclk = 1'b1;
         rx[i] = sdo;
         #62.5 sclk = 1'b0;
      end
   endtask
   task automatic xfer(input rcc_byte_t a, input rcc_byte_t wd [$]);
      rcc_byte_t r;
      cs_n = 1'b0;
      #100;
      shift(a, r);
      foreach (wd[k]) begin
         shift(wd[k], r);
         if (!a[7]) begin
            rx_byte = r;
            rx_done = 1'b1;
            #10 rx_done = 1'b0;
         end
      end
      #100 cs_n = 1'b1;
      // Released line must not keep showing the last bit
      sdi = ~sdi;
      #300;
   endtask
endmodule
